// ---- dv/asf_bench.sv ----
`include "asf_consts.svh"
`default_nettype none
module asf_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, smp_valid, smp_ready, trig, reg_wr, reg_rd, interrupt_pin_one;
  logic [15:0] smp_x, smp_y, smp_z;
  logic [1:0] res_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  int err_count, cmp_count, cyc;
  // ---------------------------------------------------------------
  // device and host
  // ---------------------------------------------------------------
  asf_top dut (.clk(clk), .rst(rst), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z), .res_sel(res_sel), .trig(trig),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .interrupt_pin_one(interrupt_pin_one));
  asf_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] vx(input int k);
    return {8'(k), 8'h37};
  endfunction : vx
  function automatic logic [15:0] vy(input int k);
    return {8'(k + 64), 8'h9c};
  endfunction : vy
  function automatic logic [15:0] vz(input int k);
    return {8'hc3 ^ 8'(k), 8'h5e};
  endfunction : vz
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk1
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
    host.rd(a, d);
    chk8(n, e, d);
  endtask : rdc
  // offer one set, hold it until ready is seen at an edge
  task automatic push(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    logic r;
    @(posedge clk);
    #2;
    smp_valid = 1'b1;
    smp_x = x;
    smp_y = y;
    smp_z = z;
    do begin
      @(negedge clk);
      r = smp_ready;
      @(posedge clk);
    end while (!r);
    #2;
    smp_valid = 1'b0;
    smp_x = ~x;
  endtask : push
  // six bytes of the oldest set, low byte first per axis
  task automatic rdset(input int k);
    logic [47:0] e;
    e = {vz(k), vy(k), vx(k)} & {3{16'(`ASF_MASK_HIRES)}};
    for (int i = 0; i < 6; i++) begin
      host.rd(8'h28 + 8'(i), d);
      chk8("set byte", e[8*i +: 8], d);
    end
  endtask : rdset
  // restart from bypass, fill n sets, check status and oldest set
  task automatic fill(input logic [7:0] m, input int n, input int first, input logic [7:0] st);
    host.wr(`ASF_OFS_MODE, 8'h00);
    host.wr(`ASF_OFS_MODE, m);
    for (int k = 0; k < n; k++) begin
      push(vx(k), vy(k), vz(k));
    end
    repeat (4) @(posedge clk);
    rdc(`ASF_OFS_STAT, st, "status full");
    rdset(first);
    $display("test fill mode %h done", m);
  endtask : fill
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    smp_valid = 1'b0;
    smp_x = 16'h0000;
    smp_y = 16'h0000;
    smp_z = 16'h0000;
    res_sel = 2'(asf_pkg::ASF_RES_LOWPWR);
    trig = 1'b0;
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    chk1("interrupt pin", 1'b0, interrupt_pin_one);
    chk1("smp_ready", 1'b1, smp_ready);
    rdc(`ASF_OFS_CTRL, 8'h00, "ctrl reset");
    $display("test reset done");
    // disabled: live view with low power resolution
    push(16'h1234, 16'h8765, 16'h0ff0);
    repeat (4) @(posedge clk);
    rdc(`ASF_OFS_X_LO, 8'h00, "live x lo");
    rdc(`ASF_OFS_X_HI, 8'h12, "live x hi");
    rdc(`ASF_OFS_Y_HI, 8'h87, "live y hi");
    rdc(`ASF_OFS_Z_HI, 8'h0f, "live z hi");
    host.wr(`ASF_OFS_CTRL, 8'h40);
    rdc(`ASF_OFS_CTRL, 8'h40, "ctrl enable");
    host.wr(8'h30, 8'hff);
    rdc(8'h30, 8'h00, "unmapped");
    for (int m = 0; m < 4; m++) begin
      host.wr(`ASF_OFS_MODE, 8'(m << 6));
      rdc(`ASF_OFS_MODE, 8'(m << 6), "mode field");
    end
    $display("test config done");
    res_sel = 2'(asf_pkg::ASF_RES_HIRES);
    fill(8'h40, 33, 0, 8'hdf);
    rdc(`ASF_OFS_STAT, 8'h9f, "status after read");
    host.wr(`ASF_OFS_INT_CFG, 8'h04);
    repeat (2) @(negedge clk);
    chk1("watermark route", 1'b1, interrupt_pin_one);
    host.wr(`ASF_OFS_INT_CFG, 8'h02);
    repeat (2) @(negedge clk);
    chk1("overrun cleared", 1'b0, interrupt_pin_one);
    fill(8'h80, 34, 2, 8'hdf);
    // the retrieval above cleared overrun: one more set fills the store again
    push(vx(34), vy(34), vz(34));
    host.wr(`ASF_OFS_INT_CFG, 8'h02);
    repeat (2) @(negedge clk);
    chk1("overrun route", 1'b1, interrupt_pin_one);
    rdc(`ASF_OFS_STAT, 8'hdf, "refilled status");
    trig = 1'b1;
    fill(8'hc0, 34, 0, 8'hdf);
    host.wr(`ASF_OFS_MODE, 8'h00);
    rdc(`ASF_OFS_STAT, 8'h20, "bypass status");
    host.wr(`ASF_OFS_MODE, 8'h80);
    rdc(`ASF_OFS_STAT, 8'h20, "cleared store");
    push(vx(5), vy(5), vz(5));
    repeat (4) @(posedge clk);
    rdc(`ASF_OFS_STAT, 8'h81, "one set");
    rdset(5);
    rdc(`ASF_OFS_STAT, 8'h20, "set retrieved");
    $display("test bypass done");
    end_of_test();
  end
endmodule : asf_bench
`default_nettype wire

// ---- dv/asf_host_model.sv ----
`default_nettype none
// ---------------------------------------------------------------
// host side of the register strobe port
// ---------------------------------------------------------------
module asf_host_model (
  input wire logic clk, // clock
  input wire logic [7:0] reg_rdata, // read data from the device
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_addr, // register offset
  output logic [7:0] reg_wdata // write data
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle write strobe, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #2;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask : wr
  // one-cycle read strobe, data taken after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #2;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
  endtask : rd
endmodule : asf_host_model
`default_nettype wire

// ---- rtl/asf_consts.svh ----
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ASF_OFS_INT_CFG 8'h22
`define ASF_OFS_CTRL 8'h24
`define ASF_OFS_X_LO 8'h28
`define ASF_OFS_X_HI 8'h29
`define ASF_OFS_Y_LO 8'h2a
`define ASF_OFS_Y_HI 8'h2b
`define ASF_OFS_Z_LO 8'h2c
`define ASF_OFS_Z_HI 8'h2d
`define ASF_OFS_MODE 8'h2e
`define ASF_OFS_STAT 8'h2f
// ---------------------------------------------------------------
// field positions and sizes
// ---------------------------------------------------------------
`define ASF_CTRL_EN_BIT 6
`define ASF_INT_LVL_BIT 2
`define ASF_INT_OVR_BIT 1
`define ASF_MODE_HI 7
`define ASF_MODE_LO 6
`define ASF_TR_BIT 5
`define ASF_FTH_HI 4
`define ASF_STAT_LVL_BIT 7
`define ASF_STAT_OVR_BIT 6
`define ASF_STAT_EMPTY_BIT 5
`define ASF_SETS 32
`define ASF_FULL 6'h20
`define ASF_CNT_MAX 6'h1f
`define ASF_ALL_BYTES 6'h3f
`define ASF_SET_W 48
`define ASF_IN_DEPTH 16
// ---------------------------------------------------------------
// resolution masks for left-justified samples
// ---------------------------------------------------------------
`define ASF_MASK_HIRES 16'hfff0
`define ASF_MASK_NORMAL 16'hffc0
`define ASF_MASK_LOWPWR 16'hff00
`endif

// ---- rtl/asf_pkg.sv ----
`default_nettype none
package asf_pkg;
  // buffer behaviour, in mode field order
  typedef enum logic [1:0] {ASF_BYPASS, ASF_FILL, ASF_STREAM, ASF_S2F} asf_mode_e;
  // power mode selecting the meaningful bits per sample
  typedef enum logic [1:0] {ASF_RES_NORMAL, ASF_RES_HIRES, ASF_RES_LOWPWR} asf_res_e;
endpackage : asf_pkg
`default_nettype wire

// ---- rtl/asf_top.sv ----
`include "asf_consts.svh"
`default_nettype none

// ---------------------------------------------------------------
// input buffer with valid and ready on both sides
// ---------------------------------------------------------------
module asf_fifo #(
  parameter int W = 48,
  parameter int D = 16
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic in_valid, // producer has data
  output logic in_ready, // buffer can take data
  input wire logic [W-1:0] in_data, // data in
  output logic out_valid, // data available
  input wire logic out_ready, // consumer takes data
  output logic [W-1:0] out_data // oldest data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  logic wr, rd;

  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  assign out_data = mem[rp_q];

  // count of held words
  always_comb begin
    cnt_d = cnt_q;
    if (wr && !rd) cnt_d = cnt_q + 1'b1;
    else if (rd && !wr) cnt_d = cnt_q - 1'b1;
  end

  // pointers, count and flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (wr) wp_q <= wp_q + 1'b1;
      if (rd) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != DEPTH);
      out_valid <= (cnt_d != '0);
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (wr) mem[wp_q] <= in_data;
  end
endmodule : asf_fifo

// Behaviour
// - three axis buffers of 32 samples each, so 32 complete sets are kept.
// - each stored sample is a 16-bit two's complement, left-justified value.
// - power mode sets how many top bits are meaningful; lower bits cleared.
// - a set is six bytes: x low, x high, y low, y high, z low, z high.
// - one new set is pushed per output data rate tick.
// - a new set goes into the first empty slot while not full.
// - in stream, or stream-then-fill before trigger, at 32 sets a new set drops the oldest; next oldest is shown.
// - enabled and not bypass, output bytes 28h-2Dh show the oldest set.
// - buffer works only with enable bit b6 at 24h set; else live data.
// - four behaviours: bypass, fill-once, stream, stream-then-fill.
// - watermark and overrun can be routed onto interrupt pin one.
// - mode field 00 bypass, 01 fill-once, 10 stream, 11 stream-then-fill.
// - bypass with enable set clears the buffer and keeps it empty until mode changes.
// - fill-once stops storing at 32 sets and holds contents.
// - six-bit stored count tracks unread sets, up per push below 32, down per set read in full.
module asf_top
  import asf_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic smp_valid, // new sample set at the data rate tick
  output logic smp_ready, // input buffer has room
  input wire logic [15:0] smp_x, // x sample, left-justified
  input wire logic [15:0] smp_y, // y sample, left-justified
  input wire logic [15:0] smp_z, // z sample, left-justified
  input wire logic [1:0] res_sel, // power mode, asf_res_e
  input wire logic trig, // stream-then-fill trigger level
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
  output logic interrupt_pin_one // interrupt pin one, active high
);
  // -------------------------------------------------------------
  // functions
  // -------------------------------------------------------------
  function automatic logic [15:0] asf_just(input logic [15:0] s, input logic [1:0] r);
    logic [15:0] m;
    m = `ASF_MASK_NORMAL;
    if (r == ASF_RES_HIRES) m = `ASF_MASK_HIRES;
    else if (r == ASF_RES_LOWPWR) m = `ASF_MASK_LOWPWR;
    return s & m;
  endfunction : asf_just

  function automatic logic [7:0] asf_byte(input logic [47:0] s, input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      3'h0: b = s[7:0];
      3'h1: b = s[15:8];
      3'h2: b = s[23:16];
      3'h3: b = s[31:24];
      3'h4: b = s[39:32];
      3'h5: b = s[47:40];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : asf_byte

  // -------------------------------------------------------------
  // registers and state
  // -------------------------------------------------------------
  logic en_q;
  logic i1_lvl_q, i1_ovr_q;
  logic [1:0] mode_fld_q;
  logic tr_q;
  logic [4:0] fth_q;
  asf_mode_e mode;
  logic [47:0] store [`ASF_SETS];
  logic [4:0] wp_q, rp_q;
  logic [5:0] cnt_q;
  logic ovr_q;
  logic trig_q;
  logic [5:0] mask_q, mask_d;
  logic [47:0] view_q;
  logic f_valid, f_ready;
  logic [47:0] f_data, in_set;
  logic active, fill_stop, acc, over, host_pop, out_rd, level_hit, busy;
  logic [2:0] out_idx;
  logic [47:0] out_set;

  assign mode = asf_mode_e'(mode_fld_q);
  assign active = en_q && (mode != ASF_BYPASS);
  assign level_hit = (cnt_q > {1'b0, fth_q});

  // -------------------------------------------------------------
  // input buffer
  // -------------------------------------------------------------
  // samples justified to the chosen resolution on entry
  assign in_set = {asf_just(smp_z, res_sel), asf_just(smp_y, res_sel),
                   asf_just(smp_x, res_sel)};

  asf_fifo #(.W(`ASF_SET_W), .D(`ASF_IN_DEPTH)) u_in (
    .clk(clk),
    .rst(rst),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(in_set),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // drain stalls while the host is part way through a set
  assign busy = (mask_q != 6'h00);
  assign f_ready = !busy;
  assign fill_stop = ((mode == ASF_FILL) || (mode == ASF_S2F && trig_q))
                     && (cnt_q == `ASF_FULL);
  assign acc = f_valid && f_ready && active && !fill_stop;
  assign over = acc && (cnt_q == `ASF_FULL);

  // -------------------------------------------------------------
  // host read tracking
  // -------------------------------------------------------------
  assign out_rd = reg_rd && (reg_addr >= `ASF_OFS_X_LO) && (reg_addr <= `ASF_OFS_Z_HI);
  assign out_idx = 3'(reg_addr - `ASF_OFS_X_LO);
  assign out_set = active ? store[rp_q] : view_q;

  always_comb begin
    mask_d = mask_q;
    if (out_rd && active) mask_d = mask_q | (6'h01 << out_idx);
  end
  assign host_pop = (mask_d == `ASF_ALL_BYTES) && (cnt_q != 6'h00);

  // byte mask of the set being read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) mask_q <= 6'h00;
    else if (!active || mask_d == `ASF_ALL_BYTES) mask_q <= 6'h00;
    else mask_q <= mask_d;
  end

  // -------------------------------------------------------------
  // set store pointers and count
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= 5'h00;
      rp_q <= 5'h00;
      cnt_q <= 6'h00;
    end else if (en_q && mode == ASF_BYPASS) begin
      wp_q <= 5'h00;
      rp_q <= 5'h00;
      cnt_q <= 6'h00;
    end else begin
      if (acc) wp_q <= wp_q + 5'h01;
      if (over || host_pop) rp_q <= rp_q + 5'h01;
      if (acc && !over) cnt_q <= cnt_q + 6'h01;
      else if (host_pop) cnt_q <= cnt_q - 6'h01;
    end
  end

  // set storage, three axes per slot
  always_ff @(posedge clk) begin
    if (acc) store[wp_q] <= f_data;
  end

  // live or frozen view when the buffer is not active
  always_ff @(posedge clk or posedge rst) begin
    if (rst) view_q <= 48'h0;
    else if (!en_q && f_valid && f_ready) view_q <= f_data;
  end

  // overrun flag, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ovr_q <= 1'b0;
    else if (!active) ovr_q <= 1'b0;
    else if ((acc && cnt_q == `ASF_CNT_MAX) || over) ovr_q <= 1'b1;
    else if (host_pop) ovr_q <= 1'b0;
  end

  // trigger latch for stream-then-fill
  always_ff @(posedge clk or posedge rst) begin
    if (rst) trig_q <= 1'b0;
    else if (mode != ASF_S2F || !en_q) trig_q <= 1'b0;
    else if (trig) trig_q <= 1'b1;
  end

  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
      i1_lvl_q <= 1'b0;
      i1_ovr_q <= 1'b0;
      mode_fld_q <= 2'h0;
      tr_q <= 1'b0;
      fth_q <= 5'h00;
    end else if (reg_wr) begin
      if (reg_addr == `ASF_OFS_CTRL) begin
        en_q <= reg_wdata[`ASF_CTRL_EN_BIT];
      end else if (reg_addr == `ASF_OFS_INT_CFG) begin
        i1_lvl_q <= reg_wdata[`ASF_INT_LVL_BIT];
        i1_ovr_q <= reg_wdata[`ASF_INT_OVR_BIT];
      end else if (reg_addr == `ASF_OFS_MODE) begin
        mode_fld_q <= reg_wdata[`ASF_MODE_HI:`ASF_MODE_LO];
        tr_q <= reg_wdata[`ASF_TR_BIT];
        fth_q <= reg_wdata[`ASF_FTH_HI:0];
      end
    end
  end

  // -------------------------------------------------------------
  // register reads, unmapped offsets read zero
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) reg_rdata <= 8'h00;
    else if (reg_rd) begin
      if (reg_addr == `ASF_OFS_CTRL) begin
        reg_rdata <= 8'({7'h0, en_q} << `ASF_CTRL_EN_BIT);
      end else if (reg_addr == `ASF_OFS_INT_CFG) begin
        reg_rdata <= 8'(({7'h0, i1_lvl_q} << `ASF_INT_LVL_BIT)
                        | ({7'h0, i1_ovr_q} << `ASF_INT_OVR_BIT));
      end else if (out_rd) begin
        reg_rdata <= asf_byte(out_set, out_idx);
      end else if (reg_addr == `ASF_OFS_MODE) begin
        reg_rdata <= {mode_fld_q, tr_q, fth_q};
      end else if (reg_addr == `ASF_OFS_STAT) begin
        reg_rdata <= {level_hit && active, ovr_q, cnt_q == 6'h00,
                      (cnt_q > `ASF_CNT_MAX) ? 5'h1f : cnt_q[4:0]};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // interrupt pin one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) interrupt_pin_one <= 1'b0;
    else interrupt_pin_one <= (i1_lvl_q && level_hit && active) || (i1_ovr_q && ovr_q);
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_count_bound: assert property (@(posedge clk) disable iff (rst)
    cnt_q <= `ASF_FULL) else $error("stored count above 32");

  a_push_count: assert property (@(posedge clk) disable iff (rst)
    (acc && !over && !host_pop && active) |=> cnt_q == $past(cnt_q) + 6'h01)
    else $error("push did not raise count");

  a_overwrite_drop: assert property (@(posedge clk) disable iff (rst)
    over |=> (cnt_q == `ASF_FULL) && (rp_q == $past(rp_q) + 5'h01))
    else $error("overrun did not drop oldest");

  a_bypass_empty: assert property (@(posedge clk) disable iff (rst)
    (en_q && mode == ASF_BYPASS) [*2] |-> cnt_q == 6'h00 && !acc)
    else $error("bypass left data in buffer");

  a_fill_hold: assert property (@(posedge clk) disable iff (rst)
    (mode == ASF_FILL && cnt_q == `ASF_FULL && !host_pop && active)
      |=> $stable(wp_q) && cnt_q == `ASF_FULL)
    else $error("fill-once stored past full");

  a_host_pop: assert property (@(posedge clk) disable iff (rst)
    (host_pop && !acc && active) |=> cnt_q == $past(cnt_q) - 6'h01 && mask_q == 6'h00)
    else $error("set retrieval wrong");

  a_live_view: assert property (@(posedge clk) disable iff (rst)
    (!en_q && f_valid && f_ready) |=> view_q == $past(f_data) && !acc)
    else $error("live data not shown");

  a_int_route: assert property (@(posedge clk) disable iff (rst)
    (i1_ovr_q && ovr_q) ##1 (i1_ovr_q && ovr_q) |-> interrupt_pin_one)
    else $error("overrun not on interrupt pin");

  a_no_store_off: assert property (@(posedge clk) disable iff (rst)
    !active |=> ($stable(wp_q) && $stable(cnt_q)) || (wp_q == 5'h00 && cnt_q == 6'h00))
    else $error("store while inactive");
endmodule : asf_top
`default_nettype wire
